// [rtl/flash_status_regs.svh]
// command codes, bit positions and timing counts for the flash status block
`ifndef FLASH_STATUS_REGS_SVH
`define FLASH_STATUS_REGS_SVH

`define CMD_UNLOCK1     8'hAA
`define CMD_UNLOCK2     8'h55
`define CMD_PROGRAM     8'hA0
`define CMD_ERASE_SETUP 8'h80
`define CMD_SECTOR_ERASE 8'h30
`define CMD_BULK_ERASE  8'h10
`define CMD_RESET       8'hF0
`define ADDR_UNLOCK1    12'h555
`define ADDR_UNLOCK2    12'hAAA

`define POLL_BIT_POS    7
`define TOGGLE_BIT_POS  6
`define ERROR_BIT_POS   5
`define ETO_BIT_POS     3
`define ERASED_BYTE     8'hFF

`define CLK_MHZ         100
`define ERASE_WIN_US    100
`define PROT_HOLD_US    100
`define ERASE_WIN_CYC   (`ERASE_WIN_US * `CLK_MHZ)
`define PROT_HOLD_CYC   (`PROT_HOLD_US * `CLK_MHZ)
`define PROG_CYC        64
`define ERASE_CYC       256

`endif

// [rtl/flash_status_pkg.sv]
// types shared by the flash status block
package flash_status_pkg;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [7:0]  data;
    } bus_req_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PROG,
        ST_ERASE_WIN,
        ST_ERASE,
        ST_PROT_HOLD,
        ST_ERROR
    } alg_state_t;

endpackage

// [rtl/flash_program_erase_status.sv]
// embedded program/erase algorithm with status bit reporting
`timescale 1ns/1ns
`include "flash_status_regs.svh"

module flash_program_erase_status #(
    parameter int MAIN_SECTORS = 8,
    parameter int SEC_SECTORS  = 4,
    parameter int OFF_W        = 4,
    parameter int ERASE_WIN    = `ERASE_WIN_CYC,
    parameter int PROT_HOLD    = `PROT_HOLD_CYC,
    parameter int PROG_TIME    = `PROG_CYC,
    parameter int ERASE_TIME   = `ERASE_CYC
) (
    input  wire logic                      clk_sys_in,
    input  wire logic                      rst_in,
    input  wire flash_status_pkg::bus_req_t bus_in,
    input  wire logic [MAIN_SECTORS-1:0]   main_sector_select_in,
    input  wire logic [SEC_SECTORS-1:0]    secondary_sector_select_in,
    input  wire logic [MAIN_SECTORS-1:0]   main_protect_in,
    input  wire logic [SEC_SECTORS-1:0]    secondary_protect_in,
    input  wire logic                      fail_inject_in,
    output logic [7:0]                     rdata_out,
    output logic                           rvalid_out,
    output logic                           busy_out
);

    localparam int NSEC  = MAIN_SECTORS + SEC_SECTORS;
    localparam int SBYTE = 1 << OFF_W;
    localparam int DEPTH = NSEC * SBYTE;
    localparam int IDX_W = $clog2(DEPTH);
    localparam int SEC_W = $clog2(NSEC);

    logic [NSEC-1:0]  sel;
    logic [NSEC-1:0]  prot;
    logic             any_sel;
    logic             wr;
    logic             rd;
    logic [SEC_W-1:0] cur_sec;
    logic [IDX_W-1:0] cur_idx;

    flash_status_pkg::alg_state_t state;
    logic [2:0]       step;
    logic             erase_seq;
    logic [IDX_W-1:0] tgt_idx;
    logic [7:0]       tgt_data;
    logic [NSEC-1:0]  erase_mask;
    logic [15:0]      timer;
    logic             error_flag;
    logic             toggle;
    logic             eto;
    logic             failed;
    logic [7:0]       mem [DEPTH];

    logic             is_reset_cmd;
    logic             prog_done;
    logic             erase_done;
    logic             launch_prog;
    logic             launch_sec;
    logic             launch_bulk;
    logic             prog_bad;
    logic             timer_zero;
    logic [7:0]       status;

    // lowest active select picks the sector
    function automatic logic [SEC_W-1:0] sec_of(
        input logic [NSEC-1:0] s
    );
        logic [SEC_W-1:0] r;
        r = '0;
        for (int i = NSEC - 1; i >= 0; i--) begin
            if (s[i]) begin
                r = SEC_W'(i);
            end
        end
        return r;
    endfunction

    function automatic logic is_cmd(
        input flash_status_pkg::bus_req_t b,
        input logic [7:0]                d,
        input logic [11:0]               a
    );
        return b.data == d && b.addr == a;
    endfunction

    assign sel     = {secondary_sector_select_in,
                      main_sector_select_in};
    assign prot    = {secondary_protect_in, main_protect_in};
    assign any_sel = |sel;
    assign wr      = bus_in.wr && any_sel;
    assign rd      = bus_in.rd && any_sel;
    assign cur_sec = sec_of(sel);
    assign cur_idx = IDX_W'({cur_sec, bus_in.addr[OFF_W-1:0]});
    assign timer_zero = timer == 16'h0000;

    assign is_reset_cmd = wr && bus_in.data == `CMD_RESET;

    // fourth strobe of a program sequence
    assign launch_prog = wr && state == flash_status_pkg::ST_IDLE
                         && step == 3'h3 && !erase_seq;
    // sixth strobe of an erase sequence
    assign launch_sec  = wr && state == flash_status_pkg::ST_IDLE
                         && step == 3'h5
                         && bus_in.data == `CMD_SECTOR_ERASE;
    assign launch_bulk = wr && state == flash_status_pkg::ST_IDLE
                         && step == 3'h5
                         && is_cmd(bus_in, `CMD_BULK_ERASE,
                                   `ADDR_UNLOCK1);

    assign prog_done  = state == flash_status_pkg::ST_PROG
                        && timer_zero;
    assign erase_done = state == flash_status_pkg::ST_ERASE
                        && timer_zero;
    // a one where a zero is stored cannot be programmed
    assign prog_bad   = |(tgt_data & ~mem[tgt_idx]);

    // unlock and command step counter
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            step      <= 3'h0;
            erase_seq <= 1'b0;
        end else if (state != flash_status_pkg::ST_IDLE
                     || is_reset_cmd) begin
            step      <= 3'h0;
            erase_seq <= 1'b0;
        end else if (wr) begin
            unique case (step)
                3'h0, 3'h3: begin
                    if (step == 3'h0 || erase_seq) begin
                        step <= is_cmd(bus_in, `CMD_UNLOCK1,
                                       `ADDR_UNLOCK1)
                                ? step + 3'h1 : 3'h0;
                    end else begin
                        step <= 3'h0;
                    end
                end
                3'h1, 3'h4: begin
                    step <= is_cmd(bus_in, `CMD_UNLOCK2,
                                   `ADDR_UNLOCK2)
                            ? step + 3'h1 : 3'h0;
                    if (step == 3'h4 && !is_cmd(bus_in,
                        `CMD_UNLOCK2, `ADDR_UNLOCK2)) begin
                        erase_seq <= 1'b0;
                    end
                end
                3'h2: begin
                    if (is_cmd(bus_in, `CMD_PROGRAM,
                               `ADDR_UNLOCK1)) begin
                        step      <= 3'h3;
                        erase_seq <= 1'b0;
                    end else if (is_cmd(bus_in, `CMD_ERASE_SETUP,
                                        `ADDR_UNLOCK1)) begin
                        step      <= 3'h3;
                        erase_seq <= 1'b1;
                    end else begin
                        step <= 3'h0;
                    end
                end
                3'h5: begin
                    step      <= 3'h0;
                    erase_seq <= 1'b0;
                end
                default: begin
                    step      <= 3'h0;
                    erase_seq <= 1'b0;
                end
            endcase
        end
    end

    // algorithm sequencer
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state      <= flash_status_pkg::ST_IDLE;
            tgt_idx    <= '0;
            tgt_data   <= 8'h00;
            erase_mask <= '0;
            timer      <= 16'h0000;
            eto        <= 1'b0;
        end else begin
            if (!timer_zero) begin
                timer <= timer - 16'h0001;
            end
            unique case (state)
                flash_status_pkg::ST_IDLE: begin
                    if (launch_prog && !prot[cur_sec]) begin
                        state    <= flash_status_pkg::ST_PROG;
                        tgt_idx  <= cur_idx;
                        tgt_data <= bus_in.data;
                        timer    <= 16'(PROG_TIME);
                    end else if (launch_sec) begin
                        state      <= flash_status_pkg::ST_ERASE_WIN;
                        erase_mask <= sel;
                        eto        <= 1'b0;
                        timer      <= 16'(ERASE_WIN);
                    end else if (launch_bulk) begin
                        erase_mask <= '1;
                        eto        <= 1'b1;
                        if (&prot) begin
                            state <= flash_status_pkg::ST_PROT_HOLD;
                            timer <= 16'(PROT_HOLD);
                        end else begin
                            state <= flash_status_pkg::ST_ERASE;
                            timer <= 16'(ERASE_TIME);
                        end
                    end
                end
                flash_status_pkg::ST_ERASE_WIN: begin
                    if (wr && bus_in.data == `CMD_SECTOR_ERASE) begin
                        // another sector joins, window restarts
                        erase_mask <= erase_mask | sel;
                        timer      <= 16'(ERASE_WIN);
                        eto        <= 1'b1;
                    end else if (wr) begin
                        state <= flash_status_pkg::ST_IDLE;
                    end else if (timer_zero) begin
                        eto <= 1'b1;
                        if ((erase_mask & ~prot) == '0) begin
                            state <= flash_status_pkg::ST_PROT_HOLD;
                            timer <= 16'(PROT_HOLD);
                        end else begin
                            state <= flash_status_pkg::ST_ERASE;
                            timer <= 16'(ERASE_TIME);
                        end
                    end
                end
                flash_status_pkg::ST_PROG: begin
                    if (timer_zero) begin
                        state <= failed
                                 ? flash_status_pkg::ST_ERROR
                                 : flash_status_pkg::ST_IDLE;
                    end
                end
                flash_status_pkg::ST_ERASE: begin
                    if (timer_zero) begin
                        state <= failed
                                 ? flash_status_pkg::ST_ERROR
                                 : flash_status_pkg::ST_IDLE;
                    end
                end
                flash_status_pkg::ST_PROT_HOLD: begin
                    if (timer_zero) begin
                        state <= flash_status_pkg::ST_IDLE;
                    end
                end
                flash_status_pkg::ST_ERROR: begin
                    if (is_reset_cmd) begin
                        state <= flash_status_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign failed = fail_inject_in
                    || (state == flash_status_pkg::ST_PROG
                        && prog_bad);

    // error flag, set wins over the reset command
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            error_flag <= 1'b0;
        end else if ((prog_done || erase_done) && failed) begin
            error_flag <= 1'b1;
        end else if (is_reset_cmd
                     && state == flash_status_pkg::ST_ERROR) begin
            error_flag <= 1'b0;
        end
    end

    // array storage
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= `ERASED_BYTE;
            end
        end else if (prog_done) begin
            mem[tgt_idx] <= mem[tgt_idx] & tgt_data;
        end else if (erase_done) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (erase_mask[i / SBYTE] && !prot[i / SBYTE]) begin
                    mem[i] <= `ERASED_BYTE;
                end
            end
        end
    end

    // toggle advances on each selected read outside ST_IDLE, error state included
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            toggle <= 1'b0;
        end else if (rd && state != flash_status_pkg::ST_IDLE) begin
            toggle <= ~toggle;
        end
    end

    always_comb begin
        status = 8'h00;
        unique case (state)
            flash_status_pkg::ST_PROG,
            flash_status_pkg::ST_ERROR: begin
                status[`POLL_BIT_POS] = ~tgt_data[7];
            end
            default: begin
                status[`POLL_BIT_POS] = 1'b0;
            end
        endcase
        status[`TOGGLE_BIT_POS] = toggle;
        status[`ERROR_BIT_POS]  = error_flag;
        status[`ETO_BIT_POS]    = eto;
    end

    // read data returns status in every state but ST_IDLE, ST_ERROR included
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rdata_out  <= 8'h00;
            rvalid_out <= 1'b0;
        end else begin
            rvalid_out <= rd;
            if (rd) begin
                rdata_out <= state == flash_status_pkg::ST_IDLE
                             ? mem[cur_idx]
                             : status;
            end
        end
    end

    assign busy_out = state == flash_status_pkg::ST_PROG
                      || state == flash_status_pkg::ST_ERASE_WIN
                      || state == flash_status_pkg::ST_ERASE
                      || state == flash_status_pkg::ST_PROT_HOLD;

endmodule

// [dv/flash_status_asserts.sv]
// port checks for the flash status block
`timescale 1ns/1ns
module flash_status_asserts #(
    parameter int MAIN_SECTORS = 8,
    parameter int SEC_SECTORS  = 4
) (
    input wire logic                       clk_sys_in,
    input wire logic                       rst_in,
    input wire flash_status_pkg::bus_req_t bus_in,
    input wire logic [MAIN_SECTORS-1:0]    main_sector_select_in,
    input wire logic [SEC_SECTORS-1:0]     secondary_sector_select_in,
    input wire logic [MAIN_SECTORS-1:0]    main_protect_in,
    input wire logic [SEC_SECTORS-1:0]     secondary_protect_in,
    input wire logic [7:0]                 rdata_out,
    input wire logic                       rvalid_out,
    input wire logic                       busy_out
);
    localparam int MAXB = 400;
    logic       any_sel;
    logic       sel_rd;
    logic       sel_wr;
    logic       prot_hit;
    logic [7:0] last_wr;
    logic       erasing;
    assign any_sel  = |main_sector_select_in || |secondary_sector_select_in;
    assign sel_rd   = bus_in.rd && any_sel;
    assign sel_wr   = bus_in.wr && any_sel;
    assign prot_hit = |(main_sector_select_in & main_protect_in) || |(secondary_sector_select_in & secondary_protect_in);
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) last_wr <= 8'h00;
        else if (sel_wr) last_wr <= bus_in.data;
    end
    // set by the final erase strobe, cleared when the algorithm ends
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) erasing <= 1'b0;
        else if (sel_wr && last_wr == 8'h55 && bus_in.data inside {8'h30, 8'h10}) erasing <= 1'b1;
        else if ($fell(busy_out)) erasing <= 1'b0;
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    sequence s_busy_read; sel_rd && busy_out; endsequence
    sequence s_prog_data; sel_wr && last_wr == 8'hA0 && !busy_out; endsequence
    sequence s_gap_reads; s_busy_read ##1 !sel_rd ##1 s_busy_read; endsequence
    a_read_answer: assert property (sel_rd |=> rvalid_out) else $error("read not answered");
    a_valid_cause: assert property (rvalid_out |-> $past(sel_rd)) else $error("spurious valid");
    a_toggle_flip: assert property (s_gap_reads |=> rdata_out[6] != $past(rdata_out[6], 2))
        else $error("toggle bit did not invert");
    a_poll_erase: assert property ((s_busy_read and erasing) |=> !rdata_out[7])
        else $error("poll bit not zero in erase");
    a_busy_bounded: assert property ($rose(busy_out) |-> ##[1:MAXB] !busy_out) else $error("busy stuck");
    a_prot_ignored: assert property ((s_prog_data and prot_hit) |=> !busy_out [*4])
        else $error("protected program started");
    a_prog_start: assert property ((s_prog_data and !prot_hit) |=> busy_out)
        else $error("program not started");
    a_erase_start: assert property (sel_wr && last_wr == 8'h55 && bus_in.data == 8'h30
        && !busy_out |=> busy_out) else $error("erase not started");
endmodule

bind flash_program_erase_status flash_status_asserts #(.MAIN_SECTORS(MAIN_SECTORS), .SEC_SECTORS(SEC_SECTORS)) chk (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus_in(bus_in), .main_sector_select_in(main_sector_select_in),
    .secondary_sector_select_in(secondary_sector_select_in), .main_protect_in(main_protect_in),
    .secondary_protect_in(secondary_protect_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
    .busy_out(busy_out));

// [dv/flash_mcu_model.sv]
// microcontroller bus model, one-cycle strobes from the falling edge, at most one every two cycles
`timescale 1ns/1ns
module flash_mcu_model #(
    parameter int MAIN_SECTORS = 8
) (
    input  wire logic                  clk_sys_in,
    output flash_status_pkg::bus_req_t bus_out,
    output logic [MAIN_SECTORS-1:0]    sel_out
);
    initial begin
        bus_out = '0;
        sel_out = '0;
    end
    task automatic pick(input logic [MAIN_SECTORS-1:0] s);
        @(negedge clk_sys_in);
        sel_out = s;
    endtask
    // strobe stands for one rising edge only, then drops
    task automatic cyc(input logic r, input logic [11:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        bus_out = '{rd: r, wr: ~r, addr: a, data: d};
        @(negedge clk_sys_in);
        bus_out = '{rd: 1'b0, wr: 1'b0, addr: a, data: d};
    endtask
    // released lines show the inverse of the last value
    task automatic idle;
        @(negedge clk_sys_in);
        bus_out = '{rd: 1'b0, wr: 1'b0, addr: ~bus_out.addr, data: ~bus_out.data};
    endtask
endmodule

// [dv/flash_program_erase_status_tb.sv]
// self-checking bench for the flash status block
`timescale 1ns/1ns
module flash_program_erase_status_tb;
    logic                       clk_sys_in = 1'b0;
    logic                       rst_in = 1'b1;
    logic [7:0]                 prot = 8'h00;
    logic                       fail_inject = 1'b0;
    logic [3:0]                 ssel = 4'h0;
    logic [3:0]                 sprot = 4'h0;
    flash_status_pkg::bus_req_t bus;
    logic [7:0]                 msel;
    logic [7:0]                 rdata;
    logic                       rvalid;
    logic                       busy;
    int                         fail_count = 0;
    int                         comparisons = 0;
    int                         cycles = 0;
    int                         seed = 32'h7a921d70;
    logic [7:0]                 d;
    logic                       tog = 1'b0;
    logic [15:0]                m;
    logic [15:0]                expq[$];
    always #5 clk_sys_in = ~clk_sys_in;
    flash_mcu_model mcu (.clk_sys_in(clk_sys_in), .bus_out(bus), .sel_out(msel));
    flash_program_erase_status #(.ERASE_WIN(20), .PROT_HOLD(20), .PROG_TIME(8), .ERASE_TIME(16)) dut (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus_in(bus), .main_sector_select_in(msel),
        .secondary_sector_select_in(ssel), .main_protect_in(prot), .secondary_protect_in(sprot),
        .fail_inject_in(fail_inject), .rdata_out(rdata), .rvalid_out(rvalid), .busy_out(busy));
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic [7:0] mask);
        expq.push_back({exp & mask, mask});
        mcu.cyc(1'b1, a, 8'h00);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        mcu.cyc(1'b0, a, v);
    endtask
    task automatic unlock;
        wr(12'h555, 8'hAA);
        wr(12'hAAA, 8'h55);
    endtask
    task automatic prog(input logic [11:0] a, input logic [7:0] v);
        unlock();
        wr(12'h555, 8'hA0);
        wr(a, v);
        mcu.idle();
    endtask
    task automatic erase(input logic [11:0] a, input logic [7:0] v);
        unlock();
        wr(12'h555, 8'h80);
        unlock();
        wr(a, v);
        mcu.idle();
    endtask
    task automatic wait_busy(input logic v);
        int n;
        n = 0;
        while (busy !== v && n < 500) begin
            @(negedge clk_sys_in);
            n++;
        end
        check("busy", {7'h00, busy}, {7'h00, v});
    endtask
    // each answered read takes the oldest expectation
    always @(negedge clk_sys_in) begin
        if (rvalid === 1'b1) begin
            m = expq.size() > 0 ? expq.pop_front() : 16'hFFFF;
            check("read data", rdata & m[7:0], m[15:8]);
        end
        cycles++;
        if (cycles > 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        rst_in = 1'b0;
        d = 8'($random(seed)) & 8'hFE;
        mcu.pick(8'h01);
        rd(12'h001, 8'hFF, 8'hFF);
        prog(12'h001, d);
        wait_busy(1'b1);
        for (int i = 0; i < 3; i++) begin
            rd(12'h001, {~d[7], tog, 6'h00}, 8'hE0);
            tog = ~tog;
        end
        wait_busy(1'b0);
        rd(12'h001, d, 8'hFF);
        rd(12'h001, d, 8'hFF);
        prog(12'h001, 8'hFF);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rd(12'h001, 8'h20, 8'hA0);
        wr(12'h001, 8'h11);
        rd(12'h001, 8'h20, 8'hA0);
        wr(12'h000, 8'hF0);
        rd(12'h001, d, 8'hFF);
        fail_inject = 1'b1;
        prog(12'h002, 8'h00);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rd(12'h002, 8'hA0, 8'hA0);
        fail_inject = 1'b0;
        wr(12'h000, 8'hF0);
        mcu.pick(8'h02);
        prog(12'h003, 8'h3C);
        wait_busy(1'b1);
        wait_busy(1'b0);
        prot = 8'h02;
        prog(12'h003, 8'h00);
        repeat (6) @(negedge clk_sys_in);
        rd(12'h003, 8'h3C, 8'hFF);
        erase(12'h000, 8'h30);
        wait_busy(1'b1);
        rd(12'h003, 8'h00, 8'hE8);
        repeat (20) @(negedge clk_sys_in);
        rd(12'h003, 8'h48, 8'hE8);
        wait_busy(1'b0);
        rd(12'h003, 8'h3C, 8'hFF);
        mcu.pick(8'h01);
        erase(12'h000, 8'h30);
        wait_busy(1'b1);
        rd(12'h005, 8'h00, 8'hE8);
        repeat (22) @(negedge clk_sys_in);
        rd(12'h005, 8'h48, 8'hE8);
        wait_busy(1'b0);
        rd(12'h001, 8'hFF, 8'hFF);
        prog(12'h001, 8'h5A);
        wait_busy(1'b1);
        wait_busy(1'b0);
        erase(12'h555, 8'h10);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rd(12'h001, 8'hFF, 8'hFF);
        mcu.pick(8'h02);
        rd(12'h003, 8'h3C, 8'hFF);
        mcu.pick(8'h00);
        ssel = 4'h1;
        prog(12'h004, 8'h77);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rd(12'h004, 8'h77, 8'hFF);
        sprot = 4'h1;
        prog(12'h004, 8'h00);
        repeat (6) @(negedge clk_sys_in);
        rd(12'h004, 8'h77, 8'hFF);
        repeat (4) @(negedge clk_sys_in);
        check("queue left", 8'(expq.size()), 8'h00);
        wrap_up();
    end
endmodule
